/* rtl/low_power_pin_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pin_function_regs.svh"

// Overview of operation
// - High request pin starts low power entry
// - Low power: pads tristate, inputs, core off
// - Entry completes 800 ns after request rises
// - Normal operation resumes 200 us after fall
// - Function select chooses diagnostic or user
// - Two probes show two chosen internal nodes
// - Probes act as user pins when select low
// - Probe disable fuse is latched, re-enabled only by reset
// - Serial input diagnostic only when select high
// - Serial output diagnostic when select high or checksum runs
// - Checksum run forces serial output active
// - Quadrant clocks are user pins unless used
module low_power_pin_select #(
  parameter int NODE_COUNT = 16,
  parameter int SEL_WIDTH = 4,
  parameter int EXIT_CYCLES = `LP_EXIT_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic low_power_request,
  input wire logic function_select,
  input wire logic probe_disable_fuse,
  input wire logic checksum_active,
  input wire logic [NODE_COUNT-1:0] internal_nodes,
  input wire logic [SEL_WIDTH-1:0] probe_sel_a,
  input wire logic [SEL_WIDTH-1:0] probe_sel_b,
  input wire logic user_a_out,
  input wire logic user_a_oe,
  input wire logic user_b_out,
  input wire logic user_b_oe,
  input wire logic user_sdo_out,
  input wire logic user_sdo_oe,
  input wire logic diag_sdo_data,
  input wire logic [3:0] quadrant_clock_used,
  input wire logic [3:0] quadrant_clock_in,
  input wire logic diag_serial_in,
  output logic probe_out_a,
  output logic probe_out_a_oe,
  output logic probe_out_b,
  output logic probe_out_b_oe,
  output logic diag_serial_out,
  output logic diag_serial_out_oe,
  output logic diag_data_in,
  output logic user_sdi_in,
  output logic [3:0] quadrant_user_in,
  output logic [3:0] quadrant_clock_ctrl,
  output logic core_enable,
  output logic input_buffers_on,
  output logic low_power_active,
  output logic probe_locked
);
  import pin_function_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] lp_sync_reg;
  logic [2:0] mode_sync_reg;
  logic lp_level_reg;
  logic mode_level_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lp_sync_reg <= 3'h0;
      mode_sync_reg <= 3'h0;
      lp_level_reg <= 1'b0;
      mode_level_reg <= 1'b0;
    end else begin
      lp_sync_reg <= {lp_sync_reg[1:0], low_power_request};
      mode_sync_reg <= {mode_sync_reg[1:0], function_select};
      if (lp_sync_reg[1] == lp_sync_reg[2])
        lp_level_reg <= lp_sync_reg[2];
      if (mode_sync_reg[1] == mode_sync_reg[2])
        mode_level_reg <= mode_sync_reg[2];
    end
  end

  // ---------------------------------------------------------------
  // Low power sequencer
  // ---------------------------------------------------------------
  localparam logic [`LP_COUNT_WIDTH-1:0] ENTRY_LAST =
    `LP_COUNT_WIDTH'(`LP_ENTRY_CYCLES - 1);
  localparam logic [`LP_COUNT_WIDTH-1:0] EXIT_LAST =
    `LP_COUNT_WIDTH'(EXIT_CYCLES - 1);

  power_state_t state_reg;
  power_state_t state_next;
  logic [`LP_COUNT_WIDTH-1:0] count_reg;
  logic [`LP_COUNT_WIDTH-1:0] count_next;
  wire entry_done = (count_reg == ENTRY_LAST);
  wire exit_done = (count_reg == EXIT_LAST);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg + `LP_COUNT_WIDTH'(1);
    unique case (state_reg)
      PWR_ON: begin
        count_next = '0;
        if (lp_level_reg)
          state_next = PWR_ENTERING;
      end
      PWR_ENTERING: begin
        if (!lp_level_reg) begin
          state_next = PWR_ON;
          count_next = '0;
        end else if (entry_done) begin
          state_next = PWR_OFF;
          count_next = '0;
        end
      end
      PWR_OFF: begin
        count_next = '0;
        if (!lp_level_reg)
          state_next = PWR_WAKING;
      end
      PWR_WAKING: begin
        if (lp_level_reg) begin
          state_next = PWR_OFF;
          count_next = '0;
        end else if (exit_done) begin
          state_next = PWR_ON;
          count_next = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PWR_ON;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // ---------------------------------------------------------------
  // Check spans, kept apart from the sequencer count
  // ---------------------------------------------------------------
  localparam logic [`LP_COUNT_WIDTH-1:0] ENTRY_COUNT =
    `LP_COUNT_WIDTH'(`LP_ENTRY_CYCLES);
  localparam logic [`LP_COUNT_WIDTH-1:0] EXIT_COUNT =
    `LP_COUNT_WIDTH'(EXIT_CYCLES);

  logic [`LP_COUNT_WIDTH-1:0] entry_span_reg;
  logic [`LP_COUNT_WIDTH-1:0] wake_span_reg;
  wire [`LP_COUNT_WIDTH-1:0] entry_span_next = (state_reg == PWR_ENTERING) ?
    entry_span_reg + `LP_COUNT_WIDTH'(1) : '0;
  wire [`LP_COUNT_WIDTH-1:0] wake_span_next = (state_reg == PWR_WAKING) ?
    wake_span_reg + `LP_COUNT_WIDTH'(1) : '0;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      entry_span_reg <= '0;
      wake_span_reg <= '0;
    end else begin
      entry_span_reg <= entry_span_next;
      wake_span_reg <= wake_span_next;
    end
  end

  // ---------------------------------------------------------------
  // Pin function selection
  // ---------------------------------------------------------------
  logic locked_reg;
  wire asleep_next = (state_next == PWR_OFF) || (state_next == PWR_WAKING);
  wire locked_next = locked_reg | probe_disable_fuse;
  wire diag_mode = mode_level_reg;
  wire probe_on = diag_mode && !locked_next;
  wire node_a = internal_nodes[probe_sel_a];
  wire node_b = internal_nodes[probe_sel_b];
  wire sdo_diag = diag_mode || checksum_active;
  wire a_val = probe_on ? node_a : user_a_out;
  wire a_en = probe_on ? 1'b1 : user_a_oe;
  wire b_val = probe_on ? node_b : user_b_out;
  wire b_en = probe_on ? 1'b1 : user_b_oe;
  wire sdo_val = sdo_diag ? diag_sdo_data : user_sdo_out;
  wire sdo_en = sdo_diag ? 1'b1 : user_sdo_oe;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      locked_reg <= 1'b0;
      probe_out_a <= 1'b0;
      probe_out_a_oe <= 1'b0;
      probe_out_b <= 1'b0;
      probe_out_b_oe <= 1'b0;
      diag_serial_out <= 1'b0;
      diag_serial_out_oe <= 1'b0;
      diag_data_in <= 1'b0;
      user_sdi_in <= 1'b0;
      quadrant_user_in <= 4'h0;
      quadrant_clock_ctrl <= 4'h0;
      core_enable <= 1'b1;
      input_buffers_on <= 1'b1;
      low_power_active <= 1'b0;
    end else begin
      locked_reg <= locked_next;
      probe_out_a <= a_val;
      probe_out_a_oe <= a_en && !asleep_next;
      probe_out_b <= b_val;
      probe_out_b_oe <= b_en && !asleep_next;
      diag_serial_out <= sdo_val;
      diag_serial_out_oe <= sdo_en && !asleep_next;
      diag_data_in <= diag_mode && !asleep_next && diag_serial_in;
      user_sdi_in <= !diag_mode && !asleep_next && diag_serial_in;
      quadrant_user_in <= asleep_next ? 4'h0 :
        (quadrant_clock_in & ~quadrant_clock_used);
      quadrant_clock_ctrl <= asleep_next ? 4'h0 :
        (quadrant_clock_in & quadrant_clock_used);
      core_enable <= !asleep_next;
      input_buffers_on <= !asleep_next;
      low_power_active <= asleep_next;
    end
  end

  assign probe_locked = locked_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  entry_delay_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg == PWR_OFF && $past(state_reg) == PWR_ENTERING) |->
    entry_span_reg == ENTRY_COUNT)
    else $error("low power entry not on time");
  pads_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    low_power_active |-> !probe_out_a_oe && !probe_out_b_oe &&
    !diag_serial_out_oe && !core_enable && !input_buffers_on)
    else $error("pad or core live in low power");
  lock_sticky_a: assert property (@(posedge clock) disable iff (!reset_n)
    locked_reg |=> locked_reg && !(probe_out_a_oe && !user_a_oe &&
    $past(mode_level_reg) && !$past(user_a_oe)))
    else $error("probe lock released");
  probe_user_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!mode_level_reg && !asleep_next) |=>
    probe_out_a == $past(user_a_out) && probe_out_a_oe == $past(user_a_oe))
    else $error("probe pin not user when select low");
  probe_node_a: assert property (@(posedge clock) disable iff (!reset_n)
    (probe_on && !asleep_next) |=>
    probe_out_b == $past(node_b) && probe_out_b_oe)
    else $error("probe b does not follow node");
  checksum_drive_a: assert property (@(posedge clock) disable iff (!reset_n)
    (checksum_active && !asleep_next) |=> diag_serial_out_oe)
    else $error("serial out not driven in checksum");
  sdi_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    !mode_level_reg |=> !diag_data_in)
    else $error("serial input routed while user");
  wake_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_reg == PWR_ON && $past(state_reg) == PWR_WAKING) |->
    wake_span_reg == EXIT_COUNT && !low_power_active)
    else $error("woke before delay");
endmodule
`default_nettype wire

/* inc/pin_function_regs.svh */
`ifndef PIN_FUNCTION_REGS_SVH
`define PIN_FUNCTION_REGS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLOCK_PERIOD_PS 20000
`define LP_ENTRY_TIME_NS 800
`define LP_EXIT_TIME_US 200
`define LP_ENTRY_CYCLES ((`LP_ENTRY_TIME_NS * 1000 + \
  `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)
`define LP_EXIT_CYCLES ((`LP_EXIT_TIME_US * 1000000) / `CLOCK_PERIOD_PS)
`define LP_COUNT_WIDTH 14

`endif

/* inc/pin_function_pkg.sv */
package pin_function_pkg;
  // Low-power sequencing states, Gray coded along the path
  typedef enum logic [1:0] {
    PWR_ON = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_OFF = 2'b11,
    PWR_WAKING = 2'b10
  } power_state_t;
endpackage

/* sim/board_tool_model.sv */
`timescale 1ns/1ps
`default_nettype none
module board_tool_model (
  input wire logic clock,
  input wire logic lp_cmd,
  input wire logic mode_cmd,
  input wire logic cksum_cmd,
  input wire logic sdi_cmd,
  output logic low_power_request,
  output logic function_select,
  output logic checksum_active,
  output logic diag_serial_in
);
  logic [3:0] cmd_seen;
  // Commands are taken on the edge, pins move just after it
  initial begin
    {low_power_request, function_select} = 2'h0;
    {checksum_active, diag_serial_in} = 2'h0;
  end
  always @(posedge clock) begin
    cmd_seen = {lp_cmd, mode_cmd, cksum_cmd, sdi_cmd};
    #1;
    low_power_request <= cmd_seen[3];
    function_select <= cmd_seen[2];
    checksum_active <= cmd_seen[1];
    diag_serial_in <= cmd_seen[0];
  end
endmodule
`default_nettype wire

/* sim/low_power_pin_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module low_power_pin_select_tb;
  logic clock, reset_n, lp, mode, cks, sdi_c, fuse, dsd;
  logic low_power_request, function_select, checksum_active, diag_serial_in;
  logic [15:0] nodes;
  logic [3:0] sel_a, sel_b, q_used, q_in, q_user, q_ctrl;
  logic ua, ua_oe, ub, ub_oe, us, us_oe;
  logic pa, pa_oe, pb, pb_oe, so, so_oe, ddi, usi, core_en, ibuf, lpa, plk;
  int mismatches, checked;
  board_tool_model tool (.clock(clock), .lp_cmd(lp), .mode_cmd(mode),
    .cksum_cmd(cks), .sdi_cmd(sdi_c), .low_power_request(low_power_request),
    .function_select(function_select), .checksum_active(checksum_active),
    .diag_serial_in(diag_serial_in));
  low_power_pin_select #(.EXIT_CYCLES(20)) uut (.clock(clock),
    .reset_n(reset_n), .low_power_request(low_power_request),
    .function_select(function_select), .probe_disable_fuse(fuse),
    .checksum_active(checksum_active), .internal_nodes(nodes),
    .probe_sel_a(sel_a), .probe_sel_b(sel_b), .user_a_out(ua),
    .user_a_oe(ua_oe), .user_b_out(ub), .user_b_oe(ub_oe),
    .user_sdo_out(us), .user_sdo_oe(us_oe), .diag_sdo_data(dsd),
    .quadrant_clock_used(q_used), .quadrant_clock_in(q_in),
    .diag_serial_in(diag_serial_in), .probe_out_a(pa),
    .probe_out_a_oe(pa_oe), .probe_out_b(pb), .probe_out_b_oe(pb_oe),
    .diag_serial_out(so), .diag_serial_out_oe(so_oe), .diag_data_in(ddi),
    .user_sdi_in(usi), .quadrant_user_in(q_user),
    .quadrant_clock_ctrl(q_ctrl), .core_enable(core_en),
    .input_buffers_on(ibuf), .low_power_active(lpa), .probe_locked(plk));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic user_mode;
    mode = 1'b0;
    {ua, ua_oe, ub, ub_oe, us, us_oe, sdi_c} = 7'h6D;
    cyc(6);
    chk("probe a user", 16'h3, {pa, pa_oe});
    chk("probe b user", 16'h1, {pb, pb_oe});
    chk("sdo user", 16'h2, {so, so_oe});
    chk("sdi user", 16'h2, {usi, ddi});
  endtask
  task automatic diag_mode;
    mode = 1'b1;
    nodes = 16'h0008;
    {sel_a, sel_b} = 8'h39;
    dsd = 1'b1;
    cyc(6);
    chk("probe a node", 16'h3, {pa, pa_oe});
    chk("probe b node", 16'h1, {pb, pb_oe});
    chk("sdo diag", 16'h3, {so, so_oe});
    chk("sdi diag", 16'h1, {usi, ddi});
    nodes = 16'h0200;
    cyc(2);
    chk("probe swap", 16'h1, {pa, pb});
  endtask
  task automatic checksum_run;
    mode = 1'b0;
    {us, us_oe, dsd, cks} = 4'h9;
    cyc(6);
    chk("sdo checksum", 16'h1, {so, so_oe});
    cks = 1'b0;
    cyc(6);
    chk("sdo returned", 16'h2, {so, so_oe});
  endtask
  task automatic quadrant;
    {q_used, q_in} = 8'h5F;
    cyc(3);
    chk("quadrant", 16'hA5, {q_user, q_ctrl});
  endtask
  task automatic low_power;
    int n;
    mode = 1'b1;
    lp = 1'b1;
    n = 0;
    while (lpa !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("entry delay", 16'h1, n >= 42 && n <= 48);
    chk("pads off", 16'h0, {pa_oe, pb_oe, so_oe, core_en, ibuf, ddi});
    lp = 1'b0;
    n = 0;
    while (lpa !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("exit delay", 16'h1, n >= 23 && n <= 29);
    cyc(2);
    chk("resumed", 16'h7, {core_en, ibuf, pa_oe});
  endtask
  task automatic fuse_lock;
    nodes = 16'h0008;
    sel_a = 4'h3;
    {ua, ua_oe} = 2'h1;
    fuse = 1'b1;
    cyc(1);
    fuse = 1'b0;
    cyc(6);
    chk("locked", 16'h1, plk);
    chk("probe a locked", 16'h1, {pa, pa_oe});
    mode = 1'b0;
    cyc(6);
    mode = 1'b1;
    cyc(6);
    chk("lock kept", 16'h2, {plk, pa});
  endtask
  initial begin
    {lp, mode, cks, sdi_c, fuse, dsd} = 6'h0;
    {ua, ua_oe, ub, ub_oe, us, us_oe} = 6'h0;
    {nodes, sel_a, sel_b, q_used, q_in} = 32'h0;
    reset_n = 1'b0;
    repeat (8) @(posedge clock);
    #1 reset_n = 1'b1;
    cyc(2);
    user_mode();
    diag_mode();
    checksum_run();
    quadrant();
    low_power();
    fuse_lock();
    give_verdict();
  end
  initial begin
    #40000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
